//--- bench/meas_null_and_filter_test.sv
/* Self-checking bench of the null and filter block.
   Assumes the register header is on the include path. */
`timescale 1ns/10ps
`include "mnf_regs.vh"
module meas_null_and_filter_test;
  logic pclk, presetn, psel, penable, pwrite, res_ready, hold_rdy;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  logic e;
  logic [23:0] v;
  logic [25:0] s; // Group sum
  wire [31:0] prdata;
  wire pready, pslverr, smp_valid, smp_ready, res_valid;
  wire [23:0] smp_data, res_data;
  wire null_lamp, zero_correction_lamp, smoothing_lamp, meas_once;
  logic [23:0] exp_q[$]; // Expected results
  int n_errors, check_count, n_once, k;
  mnf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
    .null_lamp(null_lamp), .zero_correction_lamp(zero_correction_lamp),
    .smoothing_lamp(smoothing_lamp), .meas_once(meas_once));
  mnf_adc adc_u (.clk(pclk), .rst_n(presetn), .smp_ready(smp_ready),
    .smp_valid(smp_valid), .smp_data(smp_data));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ********
  // Checking and closing
  // ********
  task chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task summarize;
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Oldest note against every popped result
  always @(posedge pclk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(res_data, exp_q.pop_front());
    end
  end
  // Sink stalls at random unless held
  always @(posedge pclk) res_ready <= hold_rdy ? 1'b0 : ($urandom % 4 != 0);
  always @(posedge pclk) if (meas_once === 1'b1) n_once++;
  // ********
  // Bus and stream tasks
  // ********
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(q, want);
  endtask
  task wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] w);
    apb(1'b1, a, d);
    rd(a, w);
  endtask
  // Control word: f is {moving avg, median, ammeter}
  task ctl(input logic [1:0] m, input logic [3:0] r, input logic [2:0] f,
      input logic [2:0] ap);
    apb(1'b1, `MNF_CTRL, {20'h0, ap, f, r, m});
    repeat (2) @(posedge pclk);
  endtask
  task key(input logic [2:0] b);
    apb(1'b1, `MNF_KEYS, {29'h0, b});
    repeat (2) @(posedge pclk);
  endtask
  task smp(input logic [23:0] d, input logic x, input logic [23:0] w);
    int t;
    if (x) exp_q.push_back(w);
    adc_u.send(d, $urandom % 3);
    t = 0;
    do @(posedge pclk);
    while ((exp_q.size() != 0 || smp_ready !== 1'b1) && ++t < 400);
    if (t >= 400) chk(32'h1, 32'h0);
  endtask
  task seq(input logic [23:0] d[5], input logic [4:0] fl,
      input logic [23:0] w[5]);
    for (int j = 0; j < 5; j++) smp(d[j], fl[j], w[j]);
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    summarize;
  end
  // ********
  // Main sequence
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {res_ready, hold_rdy, presetn} = '0;
    q = $urandom(68981);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MNF_CTRL, 32'h0);
    wrd(`MNF_RANK, 32'h10, 32'h0);
    wrd(`MNF_RANK, 32'hf, 32'hf);
    wrd(`MNF_COUNT, 32'h0, 32'h1);
    wrd(`MNF_COUNT, 32'h65, 32'h1);
    wrd(`MNF_COUNT, 32'h64, 32'h64);
    ctl(2'h0, 4'h0, 3'h0, 3'h6);
    rd(`MNF_CTRL, 32'h0);
    rd(8'h1c, 32'h0);
    chk(e, 1'b1);
    ctl(2'h0, 4'h1, 3'h0, 3'h0);
    key(3'h1);
    ctl(2'h0, 4'h1, 3'h1, 3'h0);
    smp(24'h100, 1'b0, 24'h0);
    chk(zero_correction_lamp, 1'b1);
    smp(24'h350, 1'b1, 24'h250);
    ctl(2'h0, 4'h2, 3'h1, 3'h0);
    chk(zero_correction_lamp, 1'b0);
    smp(24'h350, 1'b1, 24'h350);
    smp(24'h1000, 1'b1, 24'h1000);
    key(3'h1);
    chk(null_lamp, 1'b1);
    smp(24'h1234, 1'b1, 24'h234);
    key(3'h1);
    chk(null_lamp, 1'b0);
    smp(24'h1234, 1'b1, 24'h1234);
    key(3'h1);
    ctl(2'h2, 4'h2, 3'h1, 3'h0);
    chk(null_lamp, 1'b0);
    rd(`MNF_STATUS, 32'h8);
    chk(q[3], 1'b1);
    ctl(2'h3, 4'h2, 3'h1, 3'h0);
    smp(24'h500, 1'b1, 24'h500);
    key(3'h1);
    chk(null_lamp, 1'b1);
    smp(24'h800, 1'b1, 24'h300);
    key(3'h1);
    smp(24'h800, 1'b1, 24'h800);
    chk(n_once, 32'h2);
    ctl(2'h2, 4'h2, 3'h1, 3'h2);
    s = '0;
    for (int i = 0; i < 8; i++) begin
      v = $urandom & 24'hfffff;
      s = s + v;
      smp(v, i % 4 == 3, s[25:2]);
      if (i % 4 == 3) s = '0;
    end
    wrd(`MNF_RANK, 32'h1, 32'h1);
    ctl(2'h0, 4'h2, 3'h3, 3'h0);
    key(3'h2);
    chk(smoothing_lamp, 1'b1);
    seq('{24'h1, 24'h2, 24'h64, 24'h5, 24'h6}, 5'b11100,
      '{24'h0, 24'h0, 24'h2, 24'h5, 24'h6});
    ctl(2'h2, 4'h2, 3'h3, 3'h0);
    smp(24'h64, 1'b1, 24'h64);
    wrd(`MNF_COUNT, 32'h3, 32'h3);
    ctl(2'h2, 4'h2, 3'h5, 3'h0);
    seq('{24'ha, 24'h14, 24'h21, 24'h28, 24'h1}, 5'b11100,
      '{24'h0, 24'h0, 24'h15, 24'h1f, 24'h18});
    wrd(`MNF_COUNT, 32'h2, 32'h2);
    ctl(2'h0, 4'h2, 3'h7, 3'h0);
    seq('{24'h1, 24'h2, 24'h64, 24'h5, 24'h6}, 5'b11000,
      '{24'h0, 24'h0, 24'h0, 24'h3, 24'h5});
    key(3'h4);
    chk(smoothing_lamp, 1'b0);
    smp(24'h64, 1'b1, 24'h64);
    ctl(2'h2, 4'h2, 3'h1, 3'h0);
    hold_rdy <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      v = $urandom & 24'hfffff;
      exp_q.push_back(v);
      fork
        adc_u.send(v, 0);
      join_none
      repeat (40) @(posedge pclk);
    end
    chk(smp_ready, 1'b0);
    chk(res_valid, 1'b1);
    hold_rdy <= 1'b0;
    k = 0;
    do @(posedge pclk); while (exp_q.size() != 0 && ++k < 900);
    chk(exp_q.size(), 32'h0);
    summarize;
  end
endmodule // meas_null_and_filter_test
bind mnf_top mnf_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
  .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
  .null_lamp(null_lamp), .zero_correction_lamp(zero_correction_lamp),
  .smoothing_lamp(smoothing_lamp), .meas_once(meas_once));

//--- bench/mnf_adc.sv
/* Converter sample source standing in front of the block.
   Assumes a sample is taken on a rising edge with valid and ready. */
`timescale 1ns/10ps
module mnf_adc (
  input wire clk,
  input wire rst_n,
  input wire smp_ready,
  output logic smp_valid,
  output wire [23:0] smp_data
);
  logic [23:0] hold_v; // Offered value
  logic [23:0] noise_ff; // Idle pattern
  assign smp_data = smp_valid ? hold_v : noise_ff;
  // Toggles so stale data is never read as a sample
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      noise_ff <= 24'h5a5a5a;
    else
      noise_ff <= ~noise_ff;
  end
  initial smp_valid = 1'b0;
  initial hold_v = 24'h0;
  // offer after a gap, hold until taken
  task send(input logic [23:0] v, input int gap);
    int k;
    repeat (gap + 1) @(posedge clk);
    smp_valid <= 1'b1;
    hold_v <= v;
    k = 0;
    do @(posedge clk); while (smp_ready !== 1'b1 && ++k < 2000);
    smp_valid <= 1'b0;
  endtask
endmodule // mnf_adc

//--- bench/mnf_properties.sv
/* Checker on the ports of the null and filter top.
   Bound from the bench top; sees nothing but top ports. */
`timescale 1ns/10ps
`include "mnf_regs.vh"
module mnf_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire smp_valid,
  input wire [23:0] smp_data,
  input wire smp_ready,
  input wire res_valid,
  input wire [23:0] res_data,
  input wire res_ready,
  input wire null_lamp,
  input wire zero_correction_lamp,
  input wire smoothing_lamp,
  input wire meas_once
);
  // ********
  // Shadow of the control word
  // ********
  logic [1:0] md_ff; // Mode
  logic [3:0] rg_ff; // Range
  logic am_ff; // Ammeter on
  wire acc = psel && penable && pready && pwrite; // Write lands
  wire ctl_wr = acc && paddr == `MNF_CTRL && pwdata[11:9] <= 3'h5;
  wire key_wr = acc && paddr == `MNF_KEYS; // Key press
  // Refused control writes must not move the shadow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_ff <= 2'h0;
      rg_ff <= 4'h0;
      am_ff <= 1'b0;
    end else if (ctl_wr) begin
      md_ff <= pwdata[1:0];
      rg_ff <= pwdata[5:2];
      am_ff <= pwdata[6];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait)
    else $error("access phase not answered");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_take; smp_valid && smp_ready |=> !smp_ready; endproperty
  a_take: assert property (p_take)
    else $error("sample taken but ready held");
  property p_hold;
    res_valid && !res_ready |=> res_valid && $stable(res_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result dropped before pop");
  property p_mode;
    ctl_wr && null_lamp && pwdata[1:0] != md_ff |-> ##[1:2] !null_lamp;
  endproperty
  a_mode: assert property (p_mode)
    else $error("null lamp kept over mode change");
  property p_noff;
    key_wr && pwdata[0] && am_ff && null_lamp && md_ff != 2'h3
      |-> ##[1:2] !null_lamp;
  endproperty
  a_noff: assert property (p_noff)
    else $error("null not turned off");
  property p_once; key_wr && pwdata[0] && md_ff == 2'h3 |-> ##[1:3] meas_once;
  endproperty
  a_once: assert property (p_once)
    else $error("no single measurement");
  property p_ron;
    key_wr && pwdata[0] && md_ff == 2'h3 && !null_lamp |-> ##[1:3] null_lamp;
  endproperty
  a_ron: assert property (p_ron)
    else $error("resistance null lamp off");
  property p_zc;
    ctl_wr && zero_correction_lamp && pwdata[5:2] != rg_ff
      |-> ##[1:2] !zero_correction_lamp;
  endproperty
  a_zc: assert property (p_zc)
    else $error("zero correction kept over range change");
  property p_fok; key_wr && pwdata[2:1] == 2'b01 |-> ##[1:2] smoothing_lamp;
  endproperty
  a_fok: assert property (p_fok)
    else $error("smoothing lamp not lit");
  property p_fkey;
    key_wr && pwdata[2:1] == 2'b10 && smoothing_lamp |-> ##[1:2] !smoothing_lamp;
  endproperty
  a_fkey: assert property (p_fkey)
    else $error("smoothing lamp not cleared");
  c_pop: cover property (res_valid && res_ready);
  c_null: cover property (key_wr && pwdata[0]);
  c_full: cover property (res_valid && !res_ready && !smp_ready);
endmodule // mnf_chk

//--- design/mnf_fifo.v
/*
  Result FIFO: a shift register of D words with registered output
  data and valid. Assumes one clock and an active low async reset.
*/
`timescale 1ns/10ps
module mnf_fifo #(
  parameter W = 24,
  parameter D = 8,
  parameter CW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output reg out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  // ********************************************************
  // Storage and occupancy
  // ********************************************************
  reg [W-1:0] ent_ff [0:D-1]; // Entry 0 is the head
  reg [CW-1:0] cnt_ff; // Words held
  wire push;
  wire pop;
  reg [CW-1:0] nxt_cnt;

  // Full is honest: no push while D words stand
  assign in_ready = (cnt_ff != D[CW-1:0]);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = ent_ff[0];

  // Next occupancy
  always @* begin
    nxt_cnt = cnt_ff;
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // Count and registered valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= {CW{1'b0}};
      out_valid <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_valid <= (nxt_cnt != {CW{1'b0}});
    end
  end

  // One slot per stage; a pop shifts every word toward the head
  genvar g;
  generate
    for (g = 0; g < D; g = g + 1) begin : slot
      localparam [CW-1:0] GI = g;
      always @(posedge clk) begin
        if (pop) begin
          if (push && (GI == cnt_ff - 1'b1)) begin
            ent_ff[g] <= in_data;
          end else if (g < D - 1) begin
            ent_ff[g] <= ent_ff[(g < D - 1) ? g + 1 : g];
          end
        end else if (push && (GI == cnt_ff)) begin
          ent_ff[g] <= in_data;
        end
      end
    end
  endgenerate
endmodule // mnf_fifo

//--- design/mnf_top.v
/*
  Null offset, internal zero correction and the three measurement
  filters, with an APB register slave and an 8-word result FIFO.
  Assumes samples arrive synchronous to pclk, one per valid strobe,
  and far apart compared with the few dozen cycles of processing.
*/
`timescale 1ns/10ps
`include "mnf_regs.vh"
module mnf_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire smp_valid,
  input wire [23:0] smp_data,
  output reg smp_ready,
  output wire res_valid,
  output wire [23:0] res_data,
  input wire res_ready,
  output reg null_lamp,
  output reg zero_correction_lamp,
  output reg smoothing_lamp,
  output reg meas_once
);
  // ********************************************************
  // Declarations
  // ********************************************************
  localparam [2:0] ST_IDLE = 3'h0; // Waiting for a sample
  localparam [2:0] ST_MED = 3'h1; // Median candidate scan
  localparam [2:0] ST_MAV = 3'h2; // Moving sum update
  localparam [2:0] ST_DIV = 3'h3; // Divide by count
  localparam [2:0] ST_OUT = 3'h4; // Push into FIFO

  reg [11:0] ctrl_ff; // Mode, range, ammeter, filters, aperture
  reg [3:0] rank_ff; // Median rank
  reg [6:0] count_ff; // Moving average count
  reg null_en_ff; // Null function enabled
  reg [23:0] null_ofs_ff; // Latched null offset
  reg zc_arm_ff; // Zero correction armed
  reg zc_pend_ff; // Next sample is the internal offset
  reg zc_valid_ff; // Internal offset held
  reg [3:0] zc_rng_ff; // Range of the internal offset
  reg [23:0] zc_ofs_ff; // Internal offset
  reg [23:0] last_ff; // Latest zero corrected value
  reg [2:0] state_ff;
  reg [23:0] cur_ff; // Value moving down the chain
  reg [28:0] racc_ff; // Repeating average sum
  reg [4:0] rcnt_ff; // Samples in current group
  reg [23:0] med_mem [0:30]; // Median window ring
  reg [4:0] med_wr_ff;
  reg [4:0] med_fill_ff;
  reg [4:0] ci_ff; // Median candidate index
  reg [23:0] mav_mem [0:99]; // Moving average ring
  reg [6:0] mav_wr_ff;
  reg [6:0] mav_fill_ff;
  reg [31:0] msum_ff; // Moving sum
  reg [30:0] dq_ff; // Dividend shifting into quotient
  reg [7:0] drem_ff; // Partial remainder
  reg [4:0] dcnt_ff;
  reg dneg_ff; // Sign of the moving sum

  wire acc = psel & penable & pready; // Completing APB cycle
  wire wr = acc & pwrite;
  wire [1:0] mode = ctrl_ff[`MNF_C_MODE];
  wire [3:0] range = ctrl_ff[`MNF_C_RANGE];
  wire amm_on = ctrl_ff[`MNF_C_AMM];
  wire [2:0] aper = ctrl_ff[`MNF_C_APER];
  wire [4:0] nmed = {rank_ff, 1'b1}; // 2R+1
  wire [4:0] rlen = 5'h1f >> (3'h5 - aper); // Group size minus one
  wire key_wr = wr && (paddr == `MNF_KEYS);
  wire null_key = key_wr & pwdata[`MNF_K_NULL];
  wire fok_key = key_wr & pwdata[`MNF_K_FOK];
  wire fltr_key = key_wr & pwdata[`MNF_K_FKEY];
  wire ctrl_wr = wr && (paddr == `MNF_CTRL) &&
    (pwdata[`MNF_C_APER] <= `MNF_APER_MAX); // Refused words act nowhere
  wire mode_chg = ctrl_wr && (pwdata[`MNF_C_MODE] != mode);
  wire rng_chg = ctrl_wr && (pwdata[`MNF_C_RANGE] != range);
  wire clr_win = mode_chg | rng_chg | fok_key | fltr_key |
    (wr && (paddr == `MNF_RANK || paddr == `MNF_COUNT));
  wire take = smp_valid & smp_ready & (state_ff == ST_IDLE);
  wire zc_on = zc_valid_ff && (zc_rng_ff == range);
  wire med_act = smoothing_lamp & ctrl_ff[`MNF_C_MED] &
    (mode == `MNF_MODE_CUR);
  wire mav_act = smoothing_lamp & ctrl_ff[`MNF_C_MAV];
  wire [23:0] zc_val = smp_data - (zc_on ? zc_ofs_ff : 24'h000000);
  wire [23:0] nul_val = zc_val - (null_lamp ? null_ofs_ff : 24'h000000);
  wire [28:0] rsum = racc_ff + {{5{nul_val[23]}}, nul_val};
  wire [28:0] ravg = $signed(rsum) >>> aper;
  wire [30:0] lt_vec; // Window entries ranked below candidate
  wire [23:0] cand = med_mem[ci_ff];
  wire [23:0] mold = mav_mem[mav_wr_ff];
  wire [31:0] nxt_msum = msum_ff + {{8{cur_ff[23]}}, cur_ff} -
    ((mav_fill_ff == count_ff) ? {{8{mold[23]}}, mold} : 32'h00000000);
  wire [7:0] dtry = {drem_ff[6:0], dq_ff[30]};
  wire dge = (dtry >= {1'b0, count_ff});
  wire fifo_in_ready;
  reg fifo_push;

  // Count of set bits, used for the rank of a candidate
  function [4:0] ones;
    input [30:0] v;
    integer k;
    begin
      ones = 5'h00;
      for (k = 0; k < 31; k = k + 1) begin
        ones = ones + {4'h0, v[k]};
      end
    end
  endfunction

  // ********************************************************
  // Median rank comparators
  // ********************************************************
  // Ties break on index so exactly one candidate has rank R
  genvar g;
  generate
    for (g = 0; g < 31; g = g + 1) begin : cmp
      localparam [4:0] GI = g;
      assign lt_vec[g] = (GI < nmed) &&
        (($signed(med_mem[g]) < $signed(cand)) ||
        ((med_mem[g] == cand) && (GI < ci_ff)));
    end
  endgenerate

  // ********************************************************
  // APB slave
  // ********************************************************
  // One wait state: pready rises the cycle after access starts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata <= 32'h00000000;
        case (paddr)
          `MNF_CTRL: prdata <= {20'h00000, ctrl_ff};
          `MNF_RANK: prdata <= {28'h0000000, rank_ff};
          `MNF_COUNT: prdata <= {25'h0000000, count_ff};
          `MNF_KEYS: prdata <= 32'h00000000;
          `MNF_STATUS: prdata <= {25'h0000000, zc_pend_ff, zc_arm_ff,
            null_en_ff, smoothing_lamp, zero_correction_lamp, null_lamp};
          `MNF_NULL_OFS: prdata <= {{8{null_ofs_ff[23]}}, null_ofs_ff};
          `MNF_ZC_OFS: prdata <= {{8{zc_ofs_ff[23]}}, zc_ofs_ff};
          default: pslverr <= 1'b1; // Unmapped address
        endcase
      end
    end
  end

  // ********************************************************
  // Configuration registers
  // ********************************************************
  // Out of range values are ignored, the old setting stands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `MNF_CTRL_RST;
      rank_ff <= `MNF_RANK_RST;
      count_ff <= `MNF_COUNT_RST;
    end else begin
      if (ctrl_wr && (pwdata[`MNF_C_APER] <= `MNF_APER_MAX)) begin
        ctrl_ff <= pwdata[11:0];
      end
      if (wr && (paddr == `MNF_RANK) && (pwdata[31:4] == 28'h0)) begin
        rank_ff <= pwdata[3:0];
      end
      if (wr && (paddr == `MNF_COUNT) && (pwdata[31:7] == 25'h0) &&
          (pwdata[6:0] != 7'h00) && (pwdata[6:0] <= `MNF_COUNT_MAX)) begin
        count_ff <= pwdata[6:0];
      end
    end
  end

  // ********************************************************
  // Null, zero correction and lamps
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      null_en_ff <= 1'b0;
      null_lamp <= 1'b0;
      null_ofs_ff <= 24'h000000;
      zc_arm_ff <= 1'b0;
      zc_pend_ff <= 1'b0;
      zc_valid_ff <= 1'b0;
      zc_rng_ff <= 4'h0;
      zc_ofs_ff <= 24'h000000;
      zero_correction_lamp <= 1'b0;
      smoothing_lamp <= 1'b0;
      meas_once <= 1'b0;
      last_ff <= 24'h000000;
    end else begin
      meas_once <= 1'b0;
      if (take) begin
        last_ff <= zc_val; // Present value for a null capture
      end
      if (null_key && (mode == `MNF_MODE_RES)) begin
        if (!null_lamp) begin
          null_ofs_ff <= last_ff;
          null_en_ff <= 1'b1;
          null_lamp <= 1'b1;
        end else begin
          null_en_ff <= 1'b0;
          null_lamp <= 1'b0;
        end
        meas_once <= 1'b1;
      end else if (null_key && !amm_on &&
          (mode == `MNF_MODE_CUR || mode == `MNF_MODE_CHG)) begin
        zc_arm_ff <= 1'b1;
      end else if (null_key && null_lamp) begin
        null_en_ff <= 1'b0;
        null_lamp <= 1'b0;
      end else if (null_key) begin
        null_ofs_ff <= last_ff;
        null_en_ff <= 1'b1;
        null_lamp <= 1'b1;
      end else if (mode_chg) begin
        null_lamp <= 1'b0;
      end
      if (ctrl_wr && pwdata[`MNF_C_AMM] && !amm_on && zc_arm_ff) begin
        zc_arm_ff <= 1'b0;
        zc_pend_ff <= 1'b1;
      end else if (take && zc_pend_ff) begin
        zc_pend_ff <= 1'b0;
        zc_valid_ff <= 1'b1;
        zc_ofs_ff <= smp_data;
        zc_rng_ff <= range;
      end
      zero_correction_lamp <= zc_on;
      if (fok_key) begin
        smoothing_lamp <= 1'b1;
      end else if (fltr_key && smoothing_lamp) begin
        smoothing_lamp <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Filter chain
  // ********************************************************
  // Only one sample is in flight; the input stalls meanwhile
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      smp_ready <= 1'b0;
      cur_ff <= 24'h000000;
      racc_ff <= 29'h00000000;
      rcnt_ff <= 5'h00;
      med_wr_ff <= 5'h00;
      med_fill_ff <= 5'h00;
      ci_ff <= 5'h00;
      mav_wr_ff <= 7'h00;
      mav_fill_ff <= 7'h00;
      msum_ff <= 32'h00000000;
      dq_ff <= 31'h00000000;
      drem_ff <= 8'h00;
      dcnt_ff <= 5'h00;
      dneg_ff <= 1'b0;
      fifo_push <= 1'b0;
    end else if (clr_win) begin
      state_ff <= ST_IDLE;
      smp_ready <= 1'b0;
      racc_ff <= 29'h00000000;
      rcnt_ff <= 5'h00;
      med_wr_ff <= 5'h00;
      med_fill_ff <= 5'h00;
      mav_wr_ff <= 7'h00;
      mav_fill_ff <= 7'h00;
      msum_ff <= 32'h00000000;
      fifo_push <= 1'b0;
    end else begin
      smp_ready <= (state_ff == ST_IDLE) & ~take;
      case (state_ff)
        ST_IDLE: begin
          smp_ready <= ~take;
          if (take && !zc_pend_ff) begin
            if (rcnt_ff >= rlen) begin
              rcnt_ff <= 5'h00;
              racc_ff <= 29'h00000000;
              cur_ff <= ravg[23:0];
              if (med_act) begin
                med_mem[med_wr_ff] <= ravg[23:0];
                med_wr_ff <= (med_wr_ff == nmed - 5'h01) ? 5'h00 :
                  med_wr_ff + 5'h01;
                if (med_fill_ff != nmed) begin
                  med_fill_ff <= med_fill_ff + 5'h01;
                end
                ci_ff <= 5'h00;
                if (med_fill_ff >= nmed - 5'h01) begin
                  state_ff <= ST_MED;
                end else begin
                  // Still filling: ready drops, returns next cycle
                end
              end else begin
                state_ff <= mav_act ? ST_MAV : ST_OUT;
              end
            end else begin
              rcnt_ff <= rcnt_ff + 5'h01;
              racc_ff <= rsum;
            end
          end
        end
        ST_MED: begin
          if (ones(lt_vec) == {1'b0, rank_ff}) begin
            cur_ff <= cand;
            state_ff <= mav_act ? ST_MAV : ST_OUT;
          end else begin
            ci_ff <= ci_ff + 5'h01;
          end
        end
        ST_MAV: begin
          mav_mem[mav_wr_ff] <= cur_ff;
          msum_ff <= nxt_msum;
          mav_wr_ff <= (mav_wr_ff == count_ff - 7'h01) ? 7'h00 :
            mav_wr_ff + 7'h01;
          dneg_ff <= nxt_msum[31];
          dq_ff <= nxt_msum[31] ? 31'h0 - nxt_msum[30:0] : nxt_msum[30:0];
          drem_ff <= 8'h00;
          dcnt_ff <= 5'h00;
          if (mav_fill_ff == count_ff) begin
            state_ff <= ST_DIV;
          end else if (mav_fill_ff == count_ff - 7'h01) begin
            mav_fill_ff <= count_ff;
            state_ff <= ST_DIV;
          end else begin
            mav_fill_ff <= mav_fill_ff + 7'h01;
            state_ff <= ST_IDLE;
            smp_ready <= 1'b1;
          end
        end
        ST_DIV: begin
          drem_ff <= dge ? dtry - {1'b0, count_ff} : dtry;
          dq_ff <= {dq_ff[29:0], dge};
          dcnt_ff <= dcnt_ff + 5'h01;
          if (dcnt_ff == `MNF_DIV_STEPS - 5'h01) begin
            cur_ff <= dneg_ff ? 24'h0 - {dq_ff[22:0], dge} :
              {dq_ff[22:0], dge};
            state_ff <= ST_OUT;
          end
        end
        ST_OUT: begin
          // Holds until the FIFO has room
          fifo_push <= 1'b1;
          if (fifo_push && fifo_in_ready) begin
            fifo_push <= 1'b0;
            state_ff <= ST_IDLE;
            smp_ready <= 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Result FIFO
  // ********************************************************
  // strobed results out
  mnf_fifo #(
    .W(24),
    .D(8),
    .CW(4)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(fifo_push && (state_ff == ST_OUT)),
    .in_data(cur_ff),
    .in_ready(fifo_in_ready),
    .out_valid(res_valid),
    .out_data(res_data),
    .out_ready(res_ready)
  );
endmodule // mnf_top

//--- shared/mnf_regs.vh
/*
  Register map, field positions, reset values and timing counts of the
  measurement null and filter block.
  Assumes a 32-bit APB with byte addresses on an 8-bit offset bus.
*/
`ifndef MNF_REGS_VH
`define MNF_REGS_VH

// ********************************************************
// Register offsets
// ********************************************************
`define MNF_CTRL 8'h00
`define MNF_RANK 8'h04
`define MNF_COUNT 8'h08
`define MNF_KEYS 8'h0c
`define MNF_STATUS 8'h10
`define MNF_NULL_OFS 8'h14
`define MNF_ZC_OFS 8'h18

// ********************************************************
// Control fields
// ********************************************************
`define MNF_C_MODE 1:0
`define MNF_C_RANGE 5:2
`define MNF_C_AMM 6
`define MNF_C_MED 7
`define MNF_C_MAV 8
`define MNF_C_APER 11:9

// Key register bits, write one to press
`define MNF_K_NULL 0
`define MNF_K_FOK 1
`define MNF_K_FKEY 2

// Measurement modes
`define MNF_MODE_CUR 2'h0
`define MNF_MODE_CHG 2'h1
`define MNF_MODE_VLT 2'h2
`define MNF_MODE_RES 2'h3

// ********************************************************
// Reset values and limits
// ********************************************************
`define MNF_CTRL_RST 12'h000
`define MNF_RANK_RST 4'h0
`define MNF_COUNT_RST 7'h01
`define MNF_COUNT_MAX 7'h64
`define MNF_APER_MAX 3'h5
`define MNF_DIV_STEPS 5'h1f

`endif
